// >>> logic/pfs_flash_host.sv
`timescale 1ns/1ps
`default_nettype none

module pfs_flash_host
   import pfs_pkg::*;
#(
   parameter int unsigned POLL_LIMIT = EC_CYC
)
(
   input wire logic i_mclk,
   input wire logic i_reset_n,
   input wire logic i_cmd_valid,
   input wire logic [2:0] i_cmd_op,
   input wire logic [ADDR_W-1:0] i_cmd_addr,
   input wire logic [DATA_W-1:0] i_cmd_data,
   output logic o_cmd_ready,
   output logic o_rsp_valid,
   output logic [DATA_W-1:0] o_rsp_data,
   output logic [DATA_W-1:0] o_rsp_part,
   output logic o_rsp_timeout,
   output logic o_rsp_boot,
   output logic o_ce_n,
   output logic o_oe_n,
   output logic o_we_n,
   output logic [ADDR_W-1:0] o_addr,
   output logic [DATA_W-1:0] o_dq,
   output logic o_dq_oe_n,
   input wire logic [DATA_W-1:0] i_dq
);

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ISSUE = 2'b01,
      ST_WAIT = 2'b10
   } pfs_state_e;

   typedef struct packed {
      pfs_state_e st;
      pfs_op_e op;
      logic [2:0] step;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic req;
      logic req_write;
      logic [ADDR_W-1:0] req_addr;
      logic [DATA_W-1:0] req_data;
      logic have_prev;
      logic prev_tog;
      logic [31:0] tmo;
      logic ready;
      logic rsp_valid;
      logic [DATA_W-1:0] rsp_data;
      logic [DATA_W-1:0] rsp_part;
      logic rsp_timeout;
      logic rsp_boot;
   } pfs_host_state_s;

   pfs_host_state_s q, d;
   logic cyc_done;
   logic [DATA_W-1:0] cyc_rdata;
   pfs_cyc_s cyc;
   pfs_op_e cmd_op;
   logic polling;

   // Bus cycle that a given step of an operation makes
   function automatic pfs_cyc_s step_cmd(input pfs_op_e op,
                                         input logic [2:0] step,
                                         input logic [ADDR_W-1:0] addr,
                                         input logic [DATA_W-1:0] wdata);
      pfs_cyc_s r;
      r.write = 1'b0;
      r.addr = addr;
      r.data = wdata;
      unique case (op)
         OP_READ, OP_POLL: begin
            r.write = 1'b0;
         end
         OP_WRITE: begin
            r.write = 1'b1;
         end
         OP_WRITE_POLL: begin
            // Polling reuses the programmed address unchanged
            r.write = (step == 3'h0);
         end
         OP_ID: begin
            // Upper address bits zero; only 14..0 carry the command
            case (step)
               3'h0: begin
                  r.write = 1'b1;
                  r.addr = {3'h0, CMD_ADDR_A};
                  r.data = CMD_DATA_A;
               end
               3'h1: begin
                  r.write = 1'b1;
                  r.addr = {3'h0, CMD_ADDR_B};
                  r.data = CMD_DATA_B;
               end
               3'h2: begin
                  r.write = 1'b1;
                  r.addr = {3'h0, CMD_ADDR_A};
                  r.data = CMD_ID_ENTER;
               end
               3'h3: begin
                  r.addr = ID_MAKER_ADDR;
               end
               default: begin
                  r.addr = ID_PART_ADDR;
               end
            endcase
         end
      endcase
      return r;
   endfunction

   function automatic logic in_boot(input logic [ADDR_W-1:0] a);
      // Offset form wraps below the base, so one compare covers both ends
      return (a - BOOT_LO) <= (BOOT_HI - BOOT_LO);
   endfunction

   // Unknown operation codes fall back to a plain read
   always_comb begin
      cmd_op = OP_READ;
      unique case (i_cmd_op)
         OP_WRITE: cmd_op = OP_WRITE;
         OP_ID: cmd_op = OP_ID;
         OP_POLL: cmd_op = OP_POLL;
         OP_WRITE_POLL: cmd_op = OP_WRITE_POLL;
         default: cmd_op = OP_READ;
      endcase
   end

   assign cyc = step_cmd(q.op, q.step, q.addr, q.wdata);
   assign polling = (q.op == OP_POLL) ||
                    ((q.op == OP_WRITE_POLL) && (q.step != 3'h0));

   always_comb begin
      d = q;
      d.req = 1'b0;
      d.rsp_valid = 1'b0;
      unique case (q.st)
         ST_IDLE: begin
            d.ready = 1'b1;
            if (i_cmd_valid && q.ready) begin
               d.op = cmd_op;
               d.addr = i_cmd_addr;
               d.wdata = i_cmd_data;
               d.step = 3'h0;
               d.have_prev = 1'b0;
               d.tmo = 32'h0;
               d.ready = 1'b0;
               d.rsp_timeout = 1'b0;
               // A locked boot block will drop this write
               d.rsp_boot = in_boot(i_cmd_addr) &&
                            ((cmd_op == OP_WRITE) ||
                             (cmd_op == OP_WRITE_POLL));
               d.st = ST_ISSUE;
            end
         end
         ST_ISSUE: begin
            d.req = 1'b1;
            d.req_write = cyc.write;
            d.req_addr = cyc.addr;
            d.req_data = cyc.data;
            d.st = ST_WAIT;
         end
         ST_WAIT: begin
            // Bound on how long the device may stay busy
            if (polling && (q.tmo != POLL_LIMIT)) begin
               d.tmo = q.tmo + 32'h1;
            end
            if (cyc_done) begin
               unique case (q.op)
                  OP_READ, OP_WRITE: begin
                     d.rsp_data = cyc_rdata;
                     d.rsp_valid = 1'b1;
                     d.ready = 1'b1;
                     d.st = ST_IDLE;
                  end
                  OP_ID: begin
                     if (q.step == 3'h3) begin
                        d.rsp_data = cyc_rdata;
                     end
                     if (q.step == 3'h4) begin
                        d.rsp_part = cyc_rdata;
                        d.rsp_valid = 1'b1;
                        d.ready = 1'b1;
                        d.st = ST_IDLE;
                     end else begin
                        d.step = q.step + 3'h1;
                        d.st = ST_ISSUE;
                     end
                  end
                  OP_POLL, OP_WRITE_POLL: begin
                     if (!polling) begin
                        d.step = 3'h1;
                        d.st = ST_ISSUE;
                     end else if (q.have_prev &&
                                  (q.prev_tog == cyc_rdata[TOGGLE_BIT])) begin
                        // Toggle bit equal in two reads in a row: device is idle
                        d.rsp_data = cyc_rdata;
                        d.rsp_valid = 1'b1;
                        d.ready = 1'b1;
                        d.st = ST_IDLE;
                     end else if (q.tmo == POLL_LIMIT) begin
                        d.rsp_data = cyc_rdata;
                        d.rsp_timeout = 1'b1;
                        d.rsp_valid = 1'b1;
                        d.ready = 1'b1;
                        d.st = ST_IDLE;
                     end else begin
                        // First value means nothing by itself
                        d.prev_tog = cyc_rdata[TOGGLE_BIT];
                        d.have_prev = 1'b1;
                        d.st = ST_ISSUE;
                     end
                  end
               endcase
            end
         end
         default: begin
            d.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         q <= '0;
         q.st <= ST_IDLE;
         q.op <= OP_READ;
      end else begin
         q <= d;
      end
   end

   pfs_bus_cycle u_cycle (
      .i_mclk(i_mclk),
      .i_reset_n(i_reset_n),
      .i_req(q.req),
      .i_req_write(q.req_write),
      .i_req_addr(q.req_addr),
      .i_req_data(q.req_data),
      .o_done(cyc_done),
      .o_rdata(cyc_rdata),
      .o_ce_n(o_ce_n),
      .o_oe_n(o_oe_n),
      .o_we_n(o_we_n),
      .o_addr(o_addr),
      .o_dq(o_dq),
      .o_dq_oe_n(o_dq_oe_n),
      .i_dq(i_dq)
   );

   assign o_cmd_ready = q.ready;
   assign o_rsp_valid = q.rsp_valid;
   assign o_rsp_data = q.rsp_data;
   assign o_rsp_part = q.rsp_part;
   assign o_rsp_timeout = q.rsp_timeout;
   assign o_rsp_boot = q.rsp_boot;

endmodule

`default_nettype wire

// >>> shared/pfs_pkg.sv
package pfs_pkg;

   localparam int ADDR_W = 18;
   localparam int DATA_W = 8;
   localparam int CNT_W = 8;

   localparam int CLK_PERIOD_NS = 25;
   localparam int CLK_RATE_HZ = 40_000_000;

   // Bus timing in ns, minimum figures
   localparam int T_WP_NS = 90;
   localparam int T_WPH_NS = 90;
   localparam int T_AH_NS = 50;
   localparam int STROBE_HIGH_PULSE_MIN_NS = 150;
   // Slowest speed grade, so every grade is served
   localparam int T_ACC_NS = 150;

   // Least times round up to whole cycles
   localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WPH_CYC = (T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int AH_CYC = (T_AH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OEHP_CYC = (STROBE_HIGH_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SYNC_STAGES = 2;
   // Extra cycle for the registered strobe leaving the chip
   localparam int READ_CYC = ACC_CYC + SYNC_STAGES + 1;

   // Longest internal operation times
   localparam int T_BP_US = 50;
   localparam int T_EC_S = 10;
   localparam int BP_CYC = T_BP_US * (CLK_RATE_HZ / 1_000_000);
   localparam int unsigned EC_CYC = T_EC_S * CLK_RATE_HZ;

   // Command sequence, 15 bit command address
   localparam logic [14:0] CMD_ADDR_A = 15'h5555;
   localparam logic [14:0] CMD_ADDR_B = 15'h2AAA;
   localparam logic [7:0] CMD_DATA_A = 8'hAA;
   localparam logic [7:0] CMD_DATA_B = 8'h55;
   localparam logic [7:0] CMD_ID_ENTER = 8'h90;
   localparam logic [ADDR_W-1:0] ID_MAKER_ADDR = 18'h00000;
   localparam logic [ADDR_W-1:0] ID_PART_ADDR = 18'h00001;

   localparam logic [ADDR_W-1:0] BOOT_LO = 18'h00000;
   localparam logic [ADDR_W-1:0] BOOT_HI = 18'h01FFF;

   localparam int TOGGLE_BIT = 6;

   typedef enum logic [2:0] {
      OP_READ = 3'b000,
      OP_WRITE = 3'b001,
      OP_ID = 3'b010,
      OP_POLL = 3'b011,
      OP_WRITE_POLL = 3'b100
   } pfs_op_e;

   typedef struct packed {
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } pfs_cyc_s;

endpackage

// >>> logic/pfs_bus_cycle.sv
`timescale 1ns/1ps
`default_nettype none

module pfs_bus_cycle
   import pfs_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_reset_n,
   input wire logic i_req,
   input wire logic i_req_write,
   input wire logic [ADDR_W-1:0] i_req_addr,
   input wire logic [DATA_W-1:0] i_req_data,
   output logic o_done,
   output logic [DATA_W-1:0] o_rdata,
   output logic o_ce_n,
   output logic o_oe_n,
   output logic o_we_n,
   output logic [ADDR_W-1:0] o_addr,
   output logic [DATA_W-1:0] o_dq,
   output logic o_dq_oe_n,
   input wire logic [DATA_W-1:0] i_dq
);

   typedef enum logic [2:0] {
      PH_IDLE = 3'b000,
      PH_SETUP = 3'b001,
      PH_STROBE = 3'b010,
      PH_HOLD = 3'b011,
      PH_RECOVER = 3'b100
   } pfs_phase_e;

   typedef struct packed {
      pfs_phase_e phase;
      logic write;
      logic [CNT_W-1:0] cnt;
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq;
      logic dq_oe_n;
      logic [DATA_W-1:0] sync1;
      logic [DATA_W-1:0] sync2;
      logic done;
      logic [DATA_W-1:0] rdata;
   } pfs_cyc_state_s;

   pfs_cyc_state_s q, d;

   always_comb begin
      d = q;
      d.done = 1'b0;
      d.sync1 = i_dq;
      d.sync2 = q.sync1;
      unique case (q.phase)
         PH_IDLE: begin
            if (i_req) begin
               d.write = i_req_write;
               d.addr = i_req_addr;
               d.dq = i_req_data;
               d.dq_oe_n = ~i_req_write;
               d.phase = PH_SETUP;
            end
         end
         PH_SETUP: begin
            // Chip enable and the data strobe fall together
            d.ce_n = 1'b0;
            if (q.write) begin
               d.we_n = 1'b0;
               d.cnt = CNT_W'(WP_CYC - 1);
            end else begin
               d.oe_n = 1'b0;
               d.cnt = CNT_W'(READ_CYC - 1);
            end
            d.phase = PH_STROBE;
         end
         PH_STROBE: begin
            if (q.cnt != '0) begin
               d.cnt = q.cnt - CNT_W'(1);
            end else if (q.write) begin
               d.we_n = 1'b1;
               d.ce_n = 1'b1;
               d.cnt = CNT_W'(AH_CYC - 1);
               d.phase = PH_HOLD;
            end else begin
               d.rdata = q.sync2;
               d.ce_n = 1'b1;
               d.oe_n = 1'b1;
               // Read strobes stay high long enough for polling
               d.cnt = CNT_W'(OEHP_CYC - 1);
               d.phase = PH_RECOVER;
            end
         end
         PH_HOLD: begin
            // Address and data held past the write strobe's rise
            if (q.cnt != '0) begin
               d.cnt = q.cnt - CNT_W'(1);
            end else begin
               d.dq_oe_n = 1'b1;
               d.cnt = CNT_W'(WPH_CYC - 1);
               d.phase = PH_RECOVER;
            end
         end
         PH_RECOVER: begin
            if (q.cnt != '0) begin
               d.cnt = q.cnt - CNT_W'(1);
            end else begin
               d.done = 1'b1;
               d.phase = PH_IDLE;
            end
         end
         default: begin
            d.phase = PH_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         q <= '0;
         q.phase <= PH_IDLE;
         q.ce_n <= 1'b1;
         q.oe_n <= 1'b1;
         q.we_n <= 1'b1;
         q.dq_oe_n <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign o_done = q.done;
   assign o_rdata = q.rdata;
   assign o_ce_n = q.ce_n;
   assign o_oe_n = q.oe_n;
   assign o_we_n = q.we_n;
   assign o_addr = q.addr;
   assign o_dq = q.dq;
   assign o_dq_oe_n = q.dq_oe_n;

endmodule

`default_nettype wire

// >>> verification/pfs_flash_model.sv
`timescale 1ns/1ps
`default_nettype none

module pfs_flash_model
   import pfs_pkg::*;
#(
   parameter logic [7:0] MAKER_CODE = 8'hA5, // Arbitrary value
   parameter logic [7:0] PART_CODE = 8'h3C, // Arbitrary value
   parameter logic [7:0] EXIT_CMD = 8'hF0,
   parameter int BUSY_READS = 3,
   parameter bit BOOT_LOCKED = 1'b1
)
(
   input wire logic i_ce_n,
   input wire logic i_oe_n,
   input wire logic i_we_n,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_stuck,
   output logic [DATA_W-1:0] o_rdata
);
   logic [7:0] mem [0:255];
   logic [7:0] cur;
   logic [7:0] last;
   logic [1:0] step;
   logic id_q;
   logic tgl;
   logic show;
   logic armed;
   int busy;
   wire wr_n = i_we_n | i_ce_n;
   wire rd_n = i_oe_n | i_ce_n;

   initial begin
      id_q = 1'b0;
      step = 2'd0;
      busy = 0;
      tgl = 1'b0;
      show = 1'b0;
      armed = 1'b0;
      last = 8'h00;
      foreach (mem[i]) mem[i] = 8'hFF;
   end

   always @(negedge wr_n) armed = 1'b1;

   // Command match on 15 address bits and 8 data bits
   always @(posedge wr_n) begin
      if (armed) begin
         if (i_addr[14:0] == CMD_ADDR_A && i_wdata == CMD_DATA_A) begin
            step = 2'd1;
         end else if (step == 2'd1 && i_addr[14:0] == CMD_ADDR_B &&
                      i_wdata == CMD_DATA_B) begin
            step = 2'd2;
         end else if (step == 2'd2 && i_addr[14:0] == CMD_ADDR_A) begin
            if (i_wdata == CMD_ID_ENTER) id_q = 1'b1;
            if (i_wdata == EXIT_CMD) id_q = 1'b0;
            step = 2'd0;
         end else begin
            step = 2'd0;
            if (!(BOOT_LOCKED && i_addr <= BOOT_HI)) begin
               mem[i_addr[7:0]] = i_wdata;
               busy = BUSY_READS;
            end
         end
      end
   end

   // Busy ends after BUSY_READS reads, unless i_stuck keeps the toggle bit running
   always @(negedge rd_n) begin
      show = (busy > 0) || i_stuck;
      if (show) tgl = ~tgl;
      if (busy > 0) busy--;
   end

   always @* begin
      if (show) cur = {mem[i_addr[7:0]][7], tgl, mem[i_addr[7:0]][5:0]};
      else if (id_q && i_addr[17:1] == 17'h00000)
         cur = i_addr[0] ? PART_CODE : MAKER_CODE;
      else cur = mem[i_addr[7:0]];
   end

   always @(posedge rd_n) last = cur;

   // Released bus shows the inverse, never a stale byte
   assign o_rdata = rd_n ? ~last : cur;
endmodule

`default_nettype wire

// >>> verification/pfs_flash_host_sva.sv
`timescale 1ns/1ps
`default_nettype none

module pfs_flash_host_sva
   import pfs_pkg::*;
#(
   parameter int unsigned POLL_LIMIT = EC_CYC
)
(
   input wire logic i_mclk,
   input wire logic i_reset_n,
   input wire logic i_cmd_valid,
   input wire logic [2:0] i_cmd_op,
   input wire logic [ADDR_W-1:0] i_cmd_addr,
   input wire logic o_cmd_ready,
   input wire logic o_rsp_valid,
   input wire logic o_rsp_boot,
   input wire logic o_ce_n,
   input wire logic o_oe_n,
   input wire logic o_we_n,
   input wire logic [ADDR_W-1:0] o_addr,
   input wire logic o_dq_oe_n
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_reset_n);

   wire take = i_cmd_valid && o_cmd_ready;
   wire wr_op = i_cmd_op == OP_WRITE || i_cmd_op == OP_WRITE_POLL;

   sequence s_rd_low;
      (!o_oe_n && !o_ce_n) [*6];
   endsequence
   sequence s_gap;
      o_oe_n [*6];
   endsequence

   property p_gap; $rose(o_oe_n) |-> s_gap; endproperty
   a_gap: assert property (p_gap) else $error("strobe high too short");
   property p_addr; !o_oe_n |-> $stable(o_addr); endproperty
   a_addr: assert property (p_addr) else $error("addr moved in read");
   property p_rd; $fell(o_oe_n) |-> s_rd_low; endproperty
   a_rd: assert property (p_rd) else $error("read strobe too short");
   property p_wp; $fell(o_we_n) |-> !o_we_n [*4]; endproperty
   a_wp: assert property (p_wp) else $error("write pulse short");
   property p_wph; $rose(o_we_n) |-> o_we_n [*4]; endproperty
   a_wph: assert property (p_wph) else $error("write high short");
   property p_drv; !o_we_n |-> !o_dq_oe_n; endproperty
   a_drv: assert property (p_drv) else $error("dq not driven");
   property p_flt; !o_oe_n |-> o_dq_oe_n; endproperty
   a_flt: assert property (p_flt) else $error("dq driven in read");
   property p_excl; o_oe_n || o_we_n; endproperty
   a_excl: assert property (p_excl) else $error("oe and we low");
   property p_boot;
      take && wr_op && i_cmd_addr <= BOOT_HI |=> !o_cmd_ready && o_rsp_boot;
   endproperty
   a_boot: assert property (p_boot) else $error("boot flag missing");
   property p_wlat;
      take && i_cmd_op == OP_WRITE |-> ##15 o_rsp_valid;
   endproperty
   a_wlat: assert property (p_wlat) else $error("write answer late");
   property p_rsp; o_rsp_valid |-> o_cmd_ready ##1 !o_rsp_valid; endproperty
   a_rsp: assert property (p_rsp) else $error("response pulse bad");
endmodule

bind pfs_flash_host pfs_flash_host_sva #(.POLL_LIMIT(POLL_LIMIT)) sva_u (
   .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_cmd_valid(i_cmd_valid),
   .i_cmd_op(i_cmd_op), .i_cmd_addr(i_cmd_addr), .o_cmd_ready(o_cmd_ready),
   .o_rsp_valid(o_rsp_valid), .o_rsp_boot(o_rsp_boot), .o_ce_n(o_ce_n),
   .o_oe_n(o_oe_n), .o_we_n(o_we_n), .o_addr(o_addr),
   .o_dq_oe_n(o_dq_oe_n));

`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb
   import pfs_pkg::*;
;
   logic i_mclk = 1'b0;
   logic i_reset_n = 1'b0;
   logic i_cmd_valid = 1'b0;
   logic [2:0] i_cmd_op = 3'b000;
   logic [ADDR_W-1:0] i_cmd_addr = '0;
   logic [DATA_W-1:0] i_cmd_data = '0;
   logic stuck = 1'b0;
   logic o_cmd_ready, o_rsp_valid, o_rsp_timeout, o_rsp_boot;
   logic o_ce_n, o_oe_n, o_we_n, o_dq_oe_n;
   logic [DATA_W-1:0] o_rsp_data, o_rsp_part, o_dq, fl_dq;
   logic [ADDR_W-1:0] o_addr;
   int mismatches = 0;
   int n_checks = 0;

   always #12.5 i_mclk = ~i_mclk;

   pfs_flash_host #(.POLL_LIMIT(200)) dut_u (
      .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_cmd_valid(i_cmd_valid),
      .i_cmd_op(i_cmd_op), .i_cmd_addr(i_cmd_addr), .i_cmd_data(i_cmd_data),
      .o_cmd_ready(o_cmd_ready), .o_rsp_valid(o_rsp_valid),
      .o_rsp_data(o_rsp_data), .o_rsp_part(o_rsp_part),
      .o_rsp_timeout(o_rsp_timeout), .o_rsp_boot(o_rsp_boot),
      .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n), .o_addr(o_addr),
      .o_dq(o_dq), .o_dq_oe_n(o_dq_oe_n), .i_dq(fl_dq));

   pfs_flash_model flash_u (
      .i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n), .i_addr(o_addr),
      .i_wdata(o_dq), .i_stuck(stuck), .o_rdata(fl_dq));

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
         mismatches++;
      end
   endtask

   task automatic cmd(input logic [2:0] op, input logic [ADDR_W-1:0] a,
                      input logic [7:0] d);
      int n;
      n = 0;
      @(posedge i_mclk);
      i_cmd_valid <= 1'b1;
      i_cmd_op <= op;
      i_cmd_addr <= a;
      i_cmd_data <= d;
      do @(posedge i_mclk); while (o_cmd_ready !== 1'b1 && ++n < 100);
      i_cmd_valid <= 1'b0;
      do @(posedge i_mclk); while (o_rsp_valid !== 1'b1 && ++n < 9000);
      if (n >= 9000) begin
         $display("[ERR] %0t rsp_valid got %h exp %h", $time, o_rsp_valid,
                  1'b1);
         mismatches++;
      end
   endtask

   task automatic t_prog();
      cmd(OP_WRITE_POLL, 18'h12345, 8'h5A);
      chk(o_rsp_data, 8'h5A);
      chk(o_rsp_timeout, 1'b0);
      chk(o_rsp_boot, 1'b0);
      cmd(OP_READ, 18'h12345, 8'h00);
      chk(o_rsp_data, 8'h5A);
   endtask

   task automatic t_id();
      // Upper address bits set: only 14..0 may count
      cmd(OP_WRITE, 18'h3D555, CMD_DATA_A);
      cmd(OP_WRITE, 18'h12AAA, CMD_DATA_B);
      cmd(OP_WRITE, 18'h05555, CMD_ID_ENTER);
      cmd(3'b111, ID_MAKER_ADDR, 8'h00);
      chk(o_rsp_data, 8'hA5);
      cmd(OP_ID, 18'h00000, 8'h00);
      chk(o_rsp_data, 8'hA5);
      chk(o_rsp_part, 8'h3C);
      cmd(OP_WRITE, 18'h05555, CMD_DATA_A);
      cmd(OP_WRITE, 18'h02AAA, CMD_DATA_B);
      cmd(OP_WRITE, 18'h05555, 8'hF0);
      // Address 0 tells ID mode from array mode; that byte is still erased
      cmd(OP_READ, ID_MAKER_ADDR, 8'h00);
      chk(o_rsp_data, 8'hFF);
   endtask

   task automatic t_boot();
      cmd(OP_WRITE_POLL, BOOT_HI, 8'h00);
      chk(o_rsp_boot, 1'b1);
      chk(o_rsp_data, 8'hFF);
      cmd(OP_WRITE_POLL, 18'h02000, 8'h11);
      chk(o_rsp_boot, 1'b0);
      chk(o_rsp_data, 8'h11);
   endtask

   task automatic t_stuck();
      stuck <= 1'b1;
      cmd(OP_POLL, 18'h02000, 8'h00);
      chk(o_rsp_timeout, 1'b1);
      stuck <= 1'b0;
      cmd(OP_POLL, 18'h02000, 8'h00);
      chk(o_rsp_timeout, 1'b0);
      chk(o_rsp_data, 8'h11);
   endtask

   initial begin
      repeat (20) @(posedge i_mclk);
      i_reset_n <= 1'b1;
      t_prog();
      t_id();
      t_boot();
      t_stuck();
      test_done();
   end

   // Whole sequence needs some 800 cycles
   initial begin
      repeat (60000) @(posedge i_mclk);
      $display("[ERR] %0t watchdog got %h exp %h", $time, 1'b1, 1'b0);
      mismatches++;
      test_done();
   end
endmodule

`default_nettype wire
